// ==== design/tmz_pkg.sv ====
`default_nettype none
package tmz_pkg;
  // word index of each register, byte address is four times it
  localparam logic [9:0] IDX_LOW = 10'h318;
  localparam logic [9:0] IDX_HIGH = 10'h319;
  localparam logic [9:0] IDX_CTL0 = 10'h31a;
  localparam logic [9:0] IDX_CTL1 = 10'h31b;
  localparam logic [9:0] IDX_STAT = 10'h31c;
  localparam logic [9:0] IDX_CLR = 10'h31d;
  localparam logic [9:0] IDX_IEN = 10'h31e;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned IDX_LSB = 2;
  // control zero fields
  localparam int unsigned C0_EN = 7;
  localparam int unsigned C0_OUT = 5;
  localparam int unsigned C0_WIDE = 4;
  localparam int unsigned C0_RATIO = 0;
  // control one fields
  localparam int unsigned C1_SRC = 5;
  localparam int unsigned C1_BYP = 4;
  localparam int unsigned C1_RATE = 0;
  // reset values, then 16-bit count top, prescaler width and source count
  localparam logic [7:0] LOW_RST = 8'h00;
  localparam logic [7:0] HIGH_RST = 8'hff;
  localparam logic [7:0] CTL_RST = 8'h00;
  localparam logic [15:0] WIDE_TOP = 16'hffff;
  localparam int unsigned PRE_W = 15;
  localparam int unsigned NSRC = 6;
  // asynchronous source inputs, bit order
  localparam int unsigned IN_PIN = 0;
  localparam int unsigned IN_CELL = 1;
  localparam int unsigned IN_SECONDARY_OSCILLATOR = 2;
  localparam int unsigned IN_MFINT = 3;
  localparam int unsigned IN_LFINT = 4;
  localparam int unsigned IN_HFINT = 5;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // count source codes
  typedef enum logic [2:0] {
    SRC_PIN = 3'b000,
    SRC_PIN_INV = 3'b001,
    SRC_INSTR = 3'b010,
    SRC_HFINT = 3'b011,
    SRC_LFINT = 3'b100,
    SRC_MFINT = 3'b101,
    SRC_SECONDARY_OSCILLATOR = 3'b110,
    SRC_CELL = 3'b111
  } tmz_src_e;
endpackage
`default_nettype wire

// ==== design/tmz_timer.sv ====
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module tmz_timer
  import tmz_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ext_pin,
  input wire logic cell_out,
  input wire logic secondary_oscillator_in,
  input wire logic mfint_in,
  input wire logic lfint_in,
  input wire logic hfint_in,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic timer_out,
  output logic irq
);
  // decoding shared by read and write paths
  function automatic logic mapped(input logic [9:0] idx);
    mapped = (idx >= IDX_LOW) && (idx <= IDX_IEN);
  endfunction

  ////////////////////////////////////////////////////////////////
  // input synchronisers
  logic [NSRC-1:0] raw;
  logic [NSRC-1:0] s1_q, s2_q, s3_q; // three-flop chain
  logic [NSRC-1:0] lvl_q, lvl_d; // agreed level
  assign raw = {hfint_in, lfint_in, mfint_in, secondary_oscillator_in, cell_out,
    ext_pin};
  genvar gi;
  // level moves only once stages two and three agree
  generate
    for (gi = 0; gi < NSRC; gi++) begin : g_lvl
      always_comb begin
        lvl_d[gi] = (s2_q[gi] == s3_q[gi]) ? s2_q[gi] : lvl_q[gi];
      end
    end
  endgenerate
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      lvl_q <= '0;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      lvl_q <= lvl_d;
    end
  end

  ////////////////////////////////////////////////////////////////
  // register fields
  logic [7:0] ctl0_q, ctl1_q;
  logic en, wide, byp;
  logic [3:0] ratio, rate;
  tmz_src_e src;
  assign en = ctl0_q[C0_EN];
  assign wide = ctl0_q[C0_WIDE];
  assign ratio = ctl0_q[C0_RATIO +: 4];
  assign src = tmz_src_e'(ctl1_q[C1_SRC +: 3]);
  assign byp = ctl1_q[C1_BYP];
  assign rate = ctl1_q[C1_RATE +: 4];
  logic clr; // prescale/postscale clear strobe

  ////////////////////////////////////////////////////////////////
  // source select, prescaler, instruction-clock sync
  logic sel_lvl, prev_q, src_edge, pre_pulse, inc;
  logic [PRE_W-1:0] pre_q, pre_d, mask;
  logic tog_q, tog_d, y1_q, y2_q, y3_q;
  always_comb begin
    unique case (src)
      SRC_PIN: sel_lvl = lvl_q[IN_PIN];
      SRC_PIN_INV: sel_lvl = ~lvl_q[IN_PIN];
      SRC_INSTR: sel_lvl = 1'b0;
      SRC_HFINT: sel_lvl = lvl_q[IN_HFINT];
      SRC_LFINT: sel_lvl = lvl_q[IN_LFINT];
      SRC_MFINT: sel_lvl = lvl_q[IN_MFINT];
      SRC_SECONDARY_OSCILLATOR: sel_lvl = lvl_q[IN_SECONDARY_OSCILLATOR];
      SRC_CELL: sel_lvl = lvl_q[IN_CELL];
    endcase
    // aclk is the instruction clock: one edge each cycle
    src_edge = (src == SRC_INSTR) ? 1'b1 : (sel_lvl & ~prev_q);
    // divide by two to the rate
    mask = PRE_W'((17'd1 << rate) - 17'd1);
    pre_pulse = en & src_edge & (pre_q == mask);
    pre_d = pre_q;
    if (clr || !en) begin
      pre_d = '0;
    end else if (src_edge) begin
      pre_d = pre_pulse ? '0 : pre_q + 1'b1;
    end
    tog_d = tog_q ^ pre_pulse;
    // else two flops into aclk, edge as enable
    inc = en & (byp ? pre_pulse : (y2_q ^ y3_q));
  end
  // sync flops kept apart from the bypass path on purpose:
  // models the documented latency of the synchronous mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_q <= 1'b0;
      pre_q <= '0;
      tog_q <= 1'b0;
      y1_q <= 1'b0;
      y2_q <= 1'b0;
      y3_q <= 1'b0;
    end else begin
      prev_q <= sel_lvl;
      pre_q <= pre_d;
      tog_q <= tog_d;
      y1_q <= tog_q;
      y2_q <= y1_q;
      y3_q <= y2_q;
    end
  end

  ////////////////////////////////////////////////////////////////
  // bus side strobes
  logic aw_have_q, w_have_q, do_wr, ar_got;
  logic [9:0] wr_idx, rd_idx;
  logic [7:0] wbyte;
  logic wr_lane;
  logic [ADDR_W-1:0] awaddr_q;
  logic [7:0] wbyte_q;
  logic wlane_q;
  assign do_wr = aw_have_q & w_have_q & ~bvalid;
  assign wr_idx = awaddr_q[ADDR_W-1:IDX_LSB];
  assign wbyte = wbyte_q;
  assign wr_lane = do_wr & wlane_q;
  assign ar_got = arvalid & arready;
  assign rd_idx = araddr[ADDR_W-1:IDX_LSB];
  logic wr_low, wr_high, wr_c0, wr_c1, rd_low;
  assign wr_low = wr_lane && (wr_idx == IDX_LOW);
  assign wr_high = wr_lane && (wr_idx == IDX_HIGH);
  assign wr_c0 = wr_lane && (wr_idx == IDX_CTL0);
  assign wr_c1 = wr_lane && (wr_idx == IDX_CTL1);
  assign rd_low = ar_got && (rd_idx == IDX_LOW);
  assign clr = wr_low | wr_c0 | wr_c1;

  ////////////////////////////////////////////////////////////////
  // counter, period, postscaler
  logic [7:0] low_q, low_d, hi_q, hi_d; // hi: count high byte
  logic [7:0] high_q, high_d, pbuf_q, pbuf_d; // register, buffer
  logic [3:0] post_q, post_d;
  logic out_q, out_d, ev, tick;
  always_comb begin
    low_d = low_q;
    hi_d = hi_q;
    high_d = high_q;
    pbuf_d = pbuf_q;
    ev = 1'b0;
    if (inc && !wide) begin
      if (low_q == pbuf_q) begin
        low_d = '0;
        pbuf_d = high_q;
        ev = 1'b1;
      end else begin
        low_d = low_q + 1'b1;
      end
    end else if (inc) begin
      {hi_d, low_d} = {hi_q, low_q} + 16'd1;
      ev = ({hi_q, low_q} == WIDE_TOP);
    end
    // read of low latches high byte
    if (rd_low && wide) begin
      high_d = hi_q;
    end
    if (wr_high) begin
      high_d = wbyte;
    end
    if (wr_low) begin
      low_d = wbyte;
      // write of low loads high byte
      if (wide) begin
        hi_d = high_q;
      end
    end
    // toggle every ratio plus one events
    tick = ev && (post_q == ratio);
    post_d = post_q;
    if (clr || !en) begin
      post_d = '0;
    end else if (ev) begin
      post_d = tick ? '0 : post_q + 1'b1;
    end
    out_d = out_q ^ tick;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      low_q <= LOW_RST;
      hi_q <= LOW_RST;
      high_q <= HIGH_RST;
      pbuf_q <= HIGH_RST;
      post_q <= '0;
      out_q <= 1'b0;
    end else begin
      low_q <= low_d;
      hi_q <= hi_d;
      high_q <= high_d;
      pbuf_q <= pbuf_d;
      post_q <= post_d;
      out_q <= out_d;
    end
  end
  assign timer_out = out_q;

  ////////////////////////////////////////////////////////////////
  // control, status and interrupt registers
  logic [7:0] ctl0_d, ctl1_d;
  logic stat_q, stat_d, ien_q, ien_d, irq_q, irq_d;
  always_comb begin
    ctl0_d = ctl0_q;
    ctl1_d = ctl1_q;
    ien_d = ien_q;
    // out bit is read-only, bit 6 unused
    if (wr_c0) begin
      ctl0_d = wbyte & ~(8'h01 << C0_OUT) & ~8'h40;
    end
    if (wr_c1) begin
      ctl1_d = wbyte;
    end
    if (wr_lane && (wr_idx == IDX_IEN)) begin
      ien_d = wbyte[0];
    end
    // set wins over a same-cycle clear
    stat_d = stat_q;
    if (wr_lane && (wr_idx == IDX_CLR) && wbyte[0]) begin
      stat_d = 1'b0;
    end
    if (tick) begin
      stat_d = 1'b1;
    end
    irq_d = stat_d & ien_d;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctl0_q <= CTL_RST;
      ctl1_q <= CTL_RST;
      stat_q <= 1'b0;
      ien_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      ctl0_q <= ctl0_d;
      ctl1_q <= ctl1_d;
      stat_q <= stat_d;
      ien_q <= ien_d;
      irq_q <= irq_d;
    end
  end
  assign irq = irq_q;

  ////////////////////////////////////////////////////////////////
  // axi4-lite slave, one write and one read at a time
  logic aw_have_d, w_have_d, awready_q, wready_q, bvalid_q;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic arready_q, arready_d, rvalid_q, rvalid_d, bvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic [7:0] rbyte;
  always_comb begin
    aw_have_d = aw_have_q | (awvalid & awready_q);
    w_have_d = w_have_q | (wvalid & wready_q);
    bvalid_d = bvalid_q & ~bready;
    bresp_d = bresp_q;
    if (do_wr) begin
      aw_have_d = 1'b0;
      w_have_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = mapped(wr_idx) ? RESP_OKAY : RESP_SLVERR;
    end
    // read view; clear and reserved slots read zero
    unique case (rd_idx)
      IDX_LOW: rbyte = low_q;
      IDX_HIGH: rbyte = high_q;
      IDX_CTL0: rbyte = ctl0_q | ({7'd0, out_q} << C0_OUT);
      IDX_CTL1: rbyte = ctl1_q;
      IDX_STAT: rbyte = {7'd0, stat_q};
      IDX_IEN: rbyte = {7'd0, ien_q};
      default: rbyte = 8'h00;
    endcase
    rvalid_d = rvalid_q & ~rready;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (ar_got) begin
      rvalid_d = 1'b1;
      rdata_d = {24'd0, rbyte};
      rresp_d = mapped(rd_idx) ? RESP_OKAY : RESP_SLVERR;
    end
    arready_d = ~rvalid_d;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
      awaddr_q <= '0;
      wbyte_q <= '0;
      wlane_q <= 1'b0;
    end else begin
      aw_have_q <= aw_have_d;
      w_have_q <= w_have_d;
      awready_q <= ~aw_have_d & ~bvalid_d;
      wready_q <= ~w_have_d & ~bvalid_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      arready_q <= arready_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
      if (awvalid && awready_q) begin
        awaddr_q <= awaddr;
      end
      if (wvalid && wready_q) begin
        wbyte_q <= wdata[7:0];
        wlane_q <= wstrb[0];
      end
    end
  end
  assign awready = awready_q;
  assign wready = wready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;

  ////////////////////////////////////////////////////////////////
  // checks
  a_period_wrap: assert property (@(posedge aclk) disable iff (!aresetn)
    inc && !wide && low_q == pbuf_q && !wr_low |=> low_q == 8'h00)
    else $error("period match did not clear low");
  a_wide_roll: assert property (@(posedge aclk) disable iff (!aresetn)
    inc && wide && {hi_q, low_q} == WIDE_TOP && !wr_low
    |=> {hi_q, low_q} == 16'h0000)
    else $error("16-bit count did not roll over");
  a_reset_vals: assert property (@(posedge aclk)
    !aresetn |=> high_q == HIGH_RST && low_q == LOW_RST && !irq)
    else $error("reset values wrong");
  a_low_latch: assert property (@(posedge aclk) disable iff (!aresetn)
    rd_low && wide && !wr_high |=> high_q == $past(hi_q))
    else $error("low read did not latch high");
  a_post_toggle: assert property (@(posedge aclk) disable iff (!aresetn)
    ev && post_q == ratio |=> timer_out != $past(timer_out) && stat_q)
    else $error("postscaler did not toggle output");
  a_pre_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    clr |=> pre_q == '0 && post_q == 4'h0)
    else $error("prescaler not cleared by write");
  a_bypass_path: assert property (@(posedge aclk) disable iff (!aresetn)
    byp && pre_pulse |-> inc)
    else $error("bypass pulse did not count");
  a_sync_delay: assert property (@(posedge aclk) disable iff (!aresetn)
    !byp && pre_pulse && !clr ##1 (!byp && en && !clr)[*2]
    |=> inc)
    else $error("synchronised pulse lost");
  a_rate_one: assert property (@(posedge aclk) disable iff (!aresetn)
    en && rate == 4'h0 && src_edge |-> pre_pulse)
    else $error("rate 1:1 did not pass every edge");
endmodule
`default_nettype wire

// ==== verif/tmz_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
module testbench
  import tmz_pkg::*;
;
  // one register access and what it should read back
  typedef struct {
    logic [9:0] idx;
    logic [7:0] wd;
    logic [7:0] rd;
    logic [1:0] rsp;
  } tmz_row_s;
  logic aclk, aresetn;
  logic [5:0] src_q; // sync_bypass count sources, one bit each
  logic [11:0] awaddr, araddr;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic awready, wready, bvalid, arready, rvalid, timer_out, irq;
  logic [1:0] bresp, rresp;
  logic last_out; // previous output level
  int tg; // output toggles seen
  int errors, checked;
  int unsigned sidx [8] = '{IN_PIN, IN_PIN, 0, IN_HFINT, IN_LFINT,
    IN_MFINT, IN_SECONDARY_OSCILLATOR, IN_CELL};
  tmz_row_s rows [10] = '{
    '{IDX_CTL1, 8'hff, 8'hff, RESP_OKAY},
    '{IDX_CTL1, 8'h00, 8'h00, RESP_OKAY},
    '{IDX_CTL0, 8'h7f, 8'h1f, RESP_OKAY}, // bit 6 reserved, bit 5 read-only
    '{IDX_CTL0, 8'h00, 8'h00, RESP_OKAY},
    '{IDX_HIGH, 8'ha5, 8'ha5, RESP_OKAY},
    '{IDX_LOW, 8'h5a, 8'h5a, RESP_OKAY},
    '{IDX_IEN, 8'h01, 8'h01, RESP_OKAY},
    '{IDX_IEN, 8'h00, 8'h00, RESP_OKAY},
    '{IDX_STAT, 8'hff, 8'h00, RESP_OKAY}, // status ignores writes
    '{10'h000, 8'hff, 8'h00, RESP_SLVERR}};
  ////////////////////////////////////////////////////////////////////////
  tmz_timer tmz_timer_i (.aclk(aclk), .aresetn(aresetn),
    .ext_pin(src_q[IN_PIN]), .cell_out(src_q[IN_CELL]),
    .secondary_oscillator_in(src_q[IN_SECONDARY_OSCILLATOR]), .mfint_in(src_q[IN_MFINT]),
    .lfint_in(src_q[IN_LFINT]), .hfint_in(src_q[IN_HFINT]),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .timer_out(timer_out), .irq(irq));
  // free-running bus clock, 100 ns
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  // count output toggles; bench reads differences only, never resets it
  always @(posedge aclk) begin
    if (timer_out !== last_out) tg <= tg + 1;
    last_out <= timer_out;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("counts: %0d compares, %0d mismatches", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, exp, input string m);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // a wait ran out of cycles: counted, then straight to the verdict
  task automatic tout(input string m);
    errors++;
    $display("mismatch at %0t: %s timed out", $time, m);
    final_report();
  endtask
  // one edge first so a released ready or valid is never raised again
  // in the same time step
  task automatic wr(input logic [11:0] a, input logic [7:0] d,
                    output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awready && awvalid) awvalid <= 1'b0;
      if (wready && wvalid) wvalid <= 1'b0;
      if (bvalid) begin
        r = bresp;
        bready <= 1'b0;
        return;
      end
      if (++n > 100) tout("write");
    end
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arready && arvalid) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        return;
      end
      if (++n > 100) tout("read");
    end
  endtask
  task automatic wreg(input logic [9:0] i, input logic [7:0] d);
    logic [1:0] r;
    wr({i, 2'b00}, d, r);
    chk(r, RESP_OKAY, "write response");
  endtask
  task automatic rchk(input logic [9:0] i, input logic [7:0] e,
                      input string m);
    logic [31:0] d;
    logic [1:0] r;
    rd({i, 2'b00}, d, r);
    chk(d, {24'h0, e}, m);
  endtask
  // n full pulses on one source, slow enough for the input filter
  task automatic pulses(input int unsigned b, input int n);
    repeat (n) begin
      src_q[b] <= 1'b1;
      repeat (6) @(posedge aclk);
      src_q[b] <= 1'b0;
      repeat (6) @(posedge aclk);
    end
    // a falling pin edge on the inverted, synchronised path only lands
    // eight edges later, so give it time before anyone reads the count
    repeat (4) @(posedge aclk);
  endtask
  // 8-bit period run from the instruction clock; first toggle may use
  // the old period buffer, so the window opens after it
  task automatic rate(input logic [7:0] p, input logic [3:0] k, r,
                      input int w, e);
    int t0, n;
    wreg(IDX_CTL0, 8'h00);
    wreg(IDX_HIGH, p);
    wreg(IDX_LOW, 8'h00);
    wreg(IDX_CTL1, {3'b010, 1'b1, k});
    wreg(IDX_CTL0, {4'h8, r});
    t0 = tg;
    n = 0;
    while (tg == t0) begin
      @(posedge aclk);
      if (++n > 5000) tout("first toggle");
    end
    t0 = tg;
    repeat (w) @(posedge aclk);
    n = tg - t0;
    // latency may shift one edge in or out of the window
    chk({31'h0, n >= e - 1 && n <= e + 1}, 1, "toggle rate");
    $display("rate test done, %0d toggles", n);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] d;
    logic [1:0] rs;
    int t0;
    aresetn = 1'b0;
    src_q = 6'h00;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 12'h000;
    araddr = 12'h000;
    wdata = 32'h0;
    wstrb = 4'h0;
    last_out = 1'b0;
    tg = 0;
    errors = 0;
    checked = 0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    // ordinary register accesses, one row each
    foreach (rows[i]) begin
      wr({rows[i].idx, 2'b00}, rows[i].wd, rs);
      chk(rs, rows[i].rsp, "write response");
      rd({rows[i].idx, 2'b00}, d, rs);
      chk(rs, rows[i].rsp, "read response");
      if (rows[i].rsp === RESP_OKAY) chk(d, {24'h0, rows[i].rd}, "data");
    end
    $display("table test done");
    // second reset in mid-run restores low, high and both control registers
    aresetn <= 1'b0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rchk(IDX_LOW, 8'h00, "low after reset");
    rchk(IDX_HIGH, 8'hff, "high after reset");
    rchk(IDX_CTL0, 8'h00, "control zero after reset");
    rchk(IDX_CTL1, 8'h00, "control one after reset");
    $display("reset test done");
    // every source code except the instruction clock, both sync modes
    for (int c = 0; c < 8; c++) begin
      if (c == 2) continue;
      for (int b = 0; b < 2; b++) begin
        wreg(IDX_CTL0, 8'h10);
        wreg(IDX_CTL1, {c[2:0], b[0], 4'h0});
        wreg(IDX_HIGH, 8'h00);
        wreg(IDX_LOW, 8'h00);
        wreg(IDX_CTL0, 8'h90);
        pulses(sidx[c], 5);
        rchk(IDX_LOW, 8'h05, "source count");
      end
    end
    $display("source test done");
    rate(8'h04, 4'h0, 4'h0, 200, 40);
    rate(8'h01, 4'h2, 4'h1, 320, 20);
    // event flag, enable and clear around the interrupt line
    wreg(IDX_CTL0, 8'h00);
    rchk(IDX_STAT, 8'h01, "event flag");
    chk(irq, 1'b0, "irq masked");
    wreg(IDX_IEN, 8'h01);
    repeat (2) @(posedge aclk);
    chk(irq, 1'b1, "irq enabled");
    wreg(IDX_CLR, 8'h01);
    repeat (2) @(posedge aclk);
    chk(irq, 1'b0, "irq cleared");
    rchk(IDX_STAT, 8'h00, "flag cleared");
    $display("interrupt test done");
    // 16-bit load through the high buffer, then rollover
    wreg(IDX_CTL1, 8'h50);
    wreg(IDX_CTL0, 8'h10);
    wreg(IDX_HIGH, 8'hff);
    wreg(IDX_LOW, 8'hfd);
    rchk(IDX_LOW, 8'hfd, "wide low");
    rchk(IDX_HIGH, 8'hff, "wide high");
    t0 = tg;
    wreg(IDX_CTL0, 8'h90);
    repeat (20) @(posedge aclk);
    wreg(IDX_CTL0, 8'h10);
    chk(tg - t0, 1, "rollover toggle");
    rd({IDX_LOW, 2'b00}, d, rs);
    rchk(IDX_HIGH, 8'h00, "high after rollover");
    $display("wide test done");
    final_report();
  end
endmodule
`default_nettype wire
